/* File: rtl/syc_pkg.sv */
// constants shared by the synchronous serial channel files
package syc_pkg;
  // register byte offsets
  localparam logic [4:0]  ADDR_CTRL      = 5'h00;
  localparam logic [4:0]  ADDR_BAUD      = 5'h04;
  localparam logic [4:0]  ADDR_TXD       = 5'h08;
  localparam logic [4:0]  ADDR_RXD       = 5'h0C;
  localparam logic [4:0]  ADDR_STAT      = 5'h10;
  // control field positions
  localparam int          CTRL_LEN_LSB   = 0;
  localparam int          CTRL_MSB_FIRST = 4;
  localparam int          CTRL_CPOL      = 5;
  localparam int          CTRL_CPHA      = 6;
  localparam int          CTRL_MASTER    = 7;
  localparam int          CTRL_EN        = 8;
  localparam int          CTRL_LOOP      = 9;
  localparam int          CTRL_TX_EN     = 10;
  localparam int          CTRL_RX_EN     = 11;
  // status bit positions
  localparam int          STAT_TX_FULL   = 0;
  localparam int          STAT_RX_FULL   = 1;
  localparam int          STAT_BUSY      = 2;
  localparam int          STAT_TX_ERR    = 3;
  localparam int          STAT_RX_ERR    = 4;
  localparam int          STAT_PH_ERR    = 5;
  localparam int          STAT_BR_ERR    = 6;
  // values after reset
  localparam logic [15:0] CTRL_RESET     = 16'h0C07;
  localparam logic [15:0] BAUD_RESET     = 16'h0001;
  // character length limits
  localparam logic [5:0]  MIN_BITS       = 6'h02;
  localparam logic [5:0]  MAX_BITS       = 6'h10;
  // bus answers
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  typedef enum logic [0:0] {
    SYC_IDLE = 1'b0,
    SYC_RUN  = 1'b1
  } syc_state_type;
endpackage : syc_pkg

/* File: rtl/syc_sticky.sv */
// one sticky flag, set wins over clear
`timescale 1ns/100ps
`default_nettype none
module syc_sticky (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // set and clear
  input  wire logic set,
  input  wire logic clr,
  // flag
  output var  logic q
);
  logic next_q;

  // a set in the clearing cycle is kept
  always_comb begin
    next_q = set | (q & ~clr);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= 1'b0;
    end else begin
      q <= next_q;
    end
  end
endmodule : syc_sticky
`default_nettype wire

/* File: rtl/syc_baud_gen.sv */
// reload counter giving one tick per shift clock half period
`timescale 1ns/100ps
`default_nettype none
module syc_baud_gen #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // control
  input  wire logic             restart,
  input  wire logic [WIDTH-1:0] reload,
  // half period tick
  output var  logic             tick
);
  logic [WIDTH-1:0] cnt;
  logic [WIDTH-1:0] next_cnt;
  logic             next_tick;

  if (WIDTH < 1 || WIDTH > 16) begin : g_chk
    $error("baud counter width must be 1 to 16");
  end

  // half period is reload+1 cycles
  always_comb begin
    next_cnt  = cnt - 1'b1;
    next_tick = 1'b0;
    if (restart) begin
      next_cnt = reload;
    end else if (cnt == '0) begin
      next_cnt  = reload;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule : syc_baud_gen
`default_nettype wire

/* File: rtl/syc_top.sv */
// synchronous serial channel with axi4-lite register access
// Summary of operation
// RULE_01: character length 2 to 16 bits
// RULE_02: master drives shift clock, slave follows it
// RULE_03: selectable lsb-first or msb-first order
// RULE_04: programmable idle clock level, both ends agree
// RULE_05: phase picks shift and latch edges
// RULE_06: full-duplex or half-duplex transfers
// RULE_07: baud generator spans the documented rate range
// RULE_08: three interrupt outputs: tx, rx, error
// RULE_09: requests on tx empty, rx full, errors
// RULE_10: transmit and receive buffer handling errors
// RULE_11: phase error and baud rate error checks
// RULE_12: loop-back routes transmit data to receiver
// RULE_13: three pins, roles follow master/slave
// RULE_14: spi compatible framing and clocking
// RULE_15: 16-bit reload, rate clk/(2*(reload+1))
// RULE_16: slave start without new data flags error
//
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/100ps
`default_nettype none
module syc_top
  import syc_pkg::*;
#(
  parameter int BAUD_WIDTH = 16
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // serial pins
  input  wire logic        sclk_i,
  output var  logic        sclk_o,
  output var  logic        sclk_oe,
  output var  logic        dout_o,
  output var  logic        dout_oe,
  input  wire logic        din_i,
  // event requests
  output var  logic        irq_tx,
  output var  logic        irq_rx,
  output var  logic        irq_err
);
  if (BAUD_WIDTH < 1 || BAUD_WIDTH > 16) begin : g_chk
    $error("baud width must be 1 to 16");
  end

  // bus side state
  logic [4:0]  aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        aw_held, next_aw_held, w_held, next_w_held;
  logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic        wr_do, rd_do;
  // registers
  logic [15:0] ctrl, next_ctrl, baud, next_baud;
  logic [15:0] tx_buf, next_tx_buf, rx_buf, next_rx_buf;
  logic        tx_full, next_tx_full, rx_full, next_rx_full;
  // engine state
  syc_state_type state, next_state;
  logic [4:0]  edge_cnt, next_edge_cnt;
  logic [15:0] tx_sr, next_tx_sr, rx_sr, next_rx_sr;
  logic        prev_sclk, edge_last, next_edge_last, ph_pend, next_ph_pend, ph_val, next_ph_val;
  logic        next_sclk_o, next_sclk_oe, next_dout_o, next_dout_oe;
  logic        next_irq_tx, next_irq_rx;
  // derived
  logic [5:0]  len;
  logic        master, cpol, cpha, msb_first, en, tx_en, rx_en, din_eff;
  logic        tick, restart, edge_now, start_m, start_s, proc, latch, last;
  logic [4:0]  ecnt;
  logic [3:0]  bidx;
  logic [4:0]  eidx;
  logic        set_tx_err, set_rx_err, set_ph_err, set_br_err;
  logic        tx_err, rx_err, ph_err, br_err, clr_w1c;
  logic [15:0] src;

  // configuration fields; lengths below two are held at two
  assign len       = (ctrl[3:0] == 4'h0) ? MIN_BITS : {2'h0, ctrl[3:0]} + 6'h01; // see RULE_01
  assign master    = ctrl[CTRL_MASTER];
  assign cpol      = ctrl[CTRL_CPOL];
  assign cpha      = ctrl[CTRL_CPHA];
  assign msb_first = ctrl[CTRL_MSB_FIRST];
  assign en        = ctrl[CTRL_EN];
  assign tx_en     = ctrl[CTRL_TX_EN];
  assign rx_en     = ctrl[CTRL_RX_EN];
  assign din_eff   = ctrl[CTRL_LOOP] ? dout_o : din_i; // see RULE_12

  // bit position inside a character for a given bit count
  function automatic logic [3:0] bit_pos(input logic [3:0] idx, input logic [5:0] n, input logic mf);
    logic [5:0] p;
    p = mf ? (n - 6'h01 - {2'h0, idx}) : {2'h0, idx};
    return p[3:0];
  endfunction : bit_pos

  // shift clock edge detection, master by tick, slave by pin change
  assign restart  = start_m;
  assign edge_now = master ? ((state == SYC_RUN) && tick) : (sclk_i != prev_sclk); // see RULE_02
  assign start_m  = (state == SYC_IDLE) && en && master && tx_full;
  assign start_s  = (state == SYC_IDLE) && en && !master && edge_now && (sclk_i != cpol); // see RULE_04
  assign proc     = ((state == SYC_RUN) && edge_now) || start_s;
  assign ecnt     = start_s ? 5'h00 : edge_cnt;
  assign latch    = cpha ? ecnt[0] : ~ecnt[0]; // see RULE_05, RULE_14
  assign last     = ({1'b0, ecnt} == ((len << 1) - 6'h01));
  assign bidx     = ecnt[4:1];
  assign eidx     = cpha ? {1'b0, bidx} : ({1'b0, bidx} + 5'h01);
  assign src      = tx_full ? tx_buf : tx_sr;

  // error flags
  assign set_tx_err = start_s && !tx_full; // see RULE_16
  assign set_rx_err = proc && last && rx_en && rx_full && !rd_do; // see RULE_10
  assign set_ph_err = ph_pend && (din_eff != ph_val); // see RULE_11
  assign set_br_err = !master && (state == SYC_RUN) && edge_now && edge_last; // see RULE_11
  assign clr_w1c    = wr_do && (aw_addr == ADDR_STAT) && w_strb[0];

  syc_sticky u_tx_err (.aclk(aclk), .aresetn(aresetn), .set(set_tx_err),
                       .clr(clr_w1c && w_data[STAT_TX_ERR]), .q(tx_err));
  syc_sticky u_rx_err (.aclk(aclk), .aresetn(aresetn), .set(set_rx_err),
                       .clr(clr_w1c && w_data[STAT_RX_ERR]), .q(rx_err));
  syc_sticky u_ph_err (.aclk(aclk), .aresetn(aresetn), .set(set_ph_err),
                       .clr(clr_w1c && w_data[STAT_PH_ERR]), .q(ph_err));
  syc_sticky u_br_err (.aclk(aclk), .aresetn(aresetn), .set(set_br_err),
                       .clr(clr_w1c && w_data[STAT_BR_ERR]), .q(br_err));

  // half period of reload+1 cycles
  syc_baud_gen #(.WIDTH(BAUD_WIDTH)) u_baud (
    .aclk    (aclk),
    .aresetn (aresetn),
    .restart (restart),
    .reload  (baud[BAUD_WIDTH-1:0]), // see RULE_15, RULE_07
    .tick    (tick)
  );

  // bus slave: address and data taken in either order, one answer each
  assign wr_do = aw_held && w_held && !s_axi_bvalid;
  assign rd_do = s_axi_arvalid && s_axi_arready && (s_axi_araddr == ADDR_RXD);
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_awready = s_axi_awready;
    next_wready  = s_axi_wready;
    next_arready = s_axi_arready;
    next_rvalid  = s_axi_rvalid;
    next_rresp   = s_axi_rresp;
    next_rdata   = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
      next_awready = 1'b0;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
      next_wready = 1'b0;
    end
    if (wr_do) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (aw_addr > ADDR_STAT || aw_addr[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid  = 1'b0;
      next_awready = 1'b1;
      next_wready  = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rresp   = RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL: next_rdata = {16'h0000, ctrl};
        ADDR_BAUD: next_rdata = {16'h0000, baud};
        ADDR_TXD:  next_rdata = {16'h0000, tx_buf};
        ADDR_RXD:  next_rdata = {16'h0000, rx_buf};
        ADDR_STAT: next_rdata = {25'h0000000, br_err, ph_err, rx_err, tx_err,
                                 (state == SYC_RUN), rx_full, tx_full};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      aw_addr       <= 5'h00;
      w_held        <= 1'b0;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
    end else begin
      aw_held       <= next_aw_held;
      aw_addr       <= next_aw_addr;
      w_held        <= next_w_held;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rresp   <= next_rresp;
      s_axi_rdata   <= next_rdata;
    end
  end

  // registers, buffers and the shift engine
  always_comb begin
    next_ctrl      = ctrl;
    next_baud      = baud;
    next_tx_buf    = tx_buf;
    next_tx_full   = tx_full;
    next_rx_buf    = rx_buf;
    next_rx_full   = rx_full && !rd_do;
    next_state     = state;
    next_edge_cnt  = edge_cnt;
    next_tx_sr     = tx_sr;
    next_rx_sr     = rx_sr;
    next_irq_tx    = 1'b0;
    next_irq_rx    = 1'b0;
    next_ph_pend   = 1'b0;
    next_ph_val    = ph_val;
    next_edge_last = proc;
    next_sclk_o    = sclk_o;
    next_sclk_oe   = en && master; // see RULE_13
    next_dout_oe   = en && tx_en; // see RULE_06
    next_dout_o    = dout_o;
    if (wr_do) begin
      for (int b = 0; b < 2; b++) begin
        if (w_strb[b]) begin
          case (aw_addr)
            ADDR_CTRL: next_ctrl[b*8 +: 8] = w_data[b*8 +: 8];
            ADDR_BAUD: next_baud[b*8 +: 8] = w_data[b*8 +: 8];
            ADDR_TXD:  next_tx_buf[b*8 +: 8] = w_data[b*8 +: 8];
            default:   next_ctrl = next_ctrl;
          endcase
        end
      end
      if (aw_addr == ADDR_TXD && w_strb[1:0] != 2'h0) begin
        next_tx_full = 1'b1;
      end
    end
    if (state == SYC_IDLE) begin
      // first bit waits on the line before the first edge
      next_dout_o = tx_en && src[bit_pos(4'h0, len, msb_first)];
      next_sclk_o = cpol; // see RULE_04
    end
    if (start_m || start_s) begin
      // buffer moves to the shifter, buffer empty event
      next_state    = SYC_RUN;
      next_edge_cnt = 5'h00;
      next_tx_sr    = src;
      next_rx_sr    = 16'h0000;
      if (tx_full) begin
        next_tx_full = (wr_do && aw_addr == ADDR_TXD) ? 1'b1 : 1'b0;
        next_irq_tx  = 1'b1; // see RULE_09
      end
    end
    if (master && state == SYC_RUN && tick) begin
      next_sclk_o = ~sclk_o; // see RULE_02
    end
    if (proc) begin
      next_edge_cnt = ecnt + 5'h01;
      if (latch) begin
        next_rx_sr[bit_pos(bidx, len, msb_first)] = din_eff; // see RULE_03
        next_ph_pend = 1'b1;
        next_ph_val  = din_eff;
      end else if ({1'b0, eidx} < len) begin
        next_dout_o = tx_en && next_tx_sr[bit_pos(eidx[3:0], len, msb_first)]; // see RULE_05
      end
      if (last) begin
        next_state = SYC_IDLE;
        if (rx_en) begin
          next_rx_buf  = next_rx_sr; // see RULE_06
          next_rx_full = 1'b1;
          next_irq_rx  = 1'b1; // see RULE_09
        end
      end
    end
    if (!en) begin
      next_state = SYC_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl      <= CTRL_RESET;
      baud      <= BAUD_RESET;
      tx_buf    <= 16'h0000;
      tx_full   <= 1'b0;
      rx_buf    <= 16'h0000;
      rx_full   <= 1'b0;
      state     <= SYC_IDLE;
      edge_cnt  <= 5'h00;
      tx_sr     <= 16'h0000;
      rx_sr     <= 16'h0000;
      prev_sclk <= 1'b0;
      edge_last <= 1'b0;
      ph_pend   <= 1'b0;
      ph_val    <= 1'b0;
      sclk_o    <= 1'b0;
      sclk_oe   <= 1'b0;
      dout_o    <= 1'b0;
      dout_oe   <= 1'b0;
      irq_tx    <= 1'b0;
      irq_rx    <= 1'b0;
      irq_err   <= 1'b0;
    end else begin
      ctrl      <= next_ctrl;
      baud      <= next_baud;
      tx_buf    <= next_tx_buf;
      tx_full   <= next_tx_full;
      rx_buf    <= next_rx_buf;
      rx_full   <= next_rx_full;
      state     <= next_state;
      edge_cnt  <= next_edge_cnt;
      tx_sr     <= next_tx_sr;
      rx_sr     <= next_rx_sr;
      prev_sclk <= sclk_i;
      edge_last <= next_edge_last;
      ph_pend   <= next_ph_pend;
      ph_val    <= next_ph_val;
      sclk_o    <= next_sclk_o;
      sclk_oe   <= next_sclk_oe;
      dout_o    <= next_dout_o;
      dout_oe   <= next_dout_oe;
      irq_tx    <= next_irq_tx; // see RULE_08
      irq_rx    <= next_irq_rx; // see RULE_08
      irq_err   <= set_tx_err | set_rx_err | set_ph_err | set_br_err; // see RULE_08
    end
  end

  // helper: cycles since the counter was loaded; the restart cycle itself is not counted,
  // and a reload changed after the load leaves the gap unmeasured until the next restart
  logic [16:0] tick_gap;
  logic        gap_ok;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_gap <= 17'h00000;
      gap_ok   <= 1'b0;
    end else begin
      tick_gap <= restart ? 17'h00000 : tick ? 17'h00001 : tick_gap + 17'h00001;
      gap_ok   <= restart ? (next_baud == baud) : (gap_ok && (next_baud == baud));
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_final_edge;
    proc && last;
  endsequence
  property p_len_edges;
    s_final_edge |-> (len >= MIN_BITS && len <= MAX_BITS) ##1 (!master || sclk_o == cpol);
  endproperty
  a_len_edges: assert property (p_len_edges) else $error("wrong edge count at end"); // see RULE_01
  property p_master_toggle;
    master && state == SYC_RUN && tick |=> sclk_o != $past(sclk_o);
  endproperty
  a_master_toggle: assert property (p_master_toggle) else $error("shift clock missed a tick"); // see RULE_02
  property p_idle_level;
    (state == SYC_IDLE && en && master && $stable(ctrl)) [*2] |-> sclk_o == cpol;
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle clock level wrong"); // see RULE_04
  property p_latch_bit;
    proc && latch |=> rx_sr[$past(bit_pos(bidx, len, msb_first))] == $past(din_eff);
  endproperty
  a_latch_bit: assert property (p_latch_bit) else $error("latched bit lost"); // see RULE_05
  property p_rx_event;
    $rose(rx_full) |-> irq_rx;
  endproperty
  a_rx_event: assert property (p_rx_event) else $error("rx full without request"); // see RULE_09
  property p_tx_err;
    start_s && !tx_full |=> tx_err && irq_err;
  endproperty
  a_tx_err: assert property (p_tx_err) else $error("missing transmit error"); // see RULE_16
  property p_rx_overrun;
    set_rx_err |=> rx_err ##1 rx_err;
  endproperty
  a_rx_overrun: assert property (p_rx_overrun) else $error("overrun not held"); // see RULE_10
  property p_baud_rate;
    tick && gap_ok && $stable(baud) |-> tick_gap == {1'b0, baud} + 17'h00001;
  endproperty
  a_baud_rate: assert property (p_baud_rate) else $error("half period not reload+1"); // see RULE_15
  property p_pin_roles;
    $stable(ctrl) |=> sclk_oe == $past(en && master) && dout_oe == $past(en && tx_en);
  endproperty
  a_pin_roles: assert property (p_pin_roles) else $error("pin drive wrong for role"); // see RULE_13
endmodule : syc_top
`default_nettype wire

/* File: sim/syc_peer.sv */
// far-side serial peripheral model for the serial channel bench
`timescale 1ns/100ps
`default_nettype none
module syc_peer (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // serial pins seen from the far side
  input  wire logic        sclk,
  input  wire logic        dout,
  output var  logic        din,
  // format agreed with the block
  input  wire logic        cpol,
  input  wire logic        cpha,
  input  wire logic        msb_first,
  input  wire logic [4:0]  len,
  // words moved
  input  wire logic [15:0] tx_word,
  output var  logic [15:0] rx_word
);
  logic prev;
  int   ns, nl, ne, idx;
  function automatic int pos(int i);
    return msb_first ? len - 1 - i : i;
  endfunction : pos
  // follows the shift clock on its sclk input, latching on one edge, shifting on the other
  always @(posedge aclk) begin
    if (!aresetn) begin
      prev <= cpol;
      ns = 0;
      nl = 0;
      ne = 0;
      din <= 1'b0;
      rx_word <= 16'h0000;
    end else begin
      prev <= sclk;
      // a level change on a polarity switch is no edge
      if (sclk !== prev && !(ne == 0 && sclk === cpol)) begin
        ne++;
        if ((sclk !== cpol) ^ cpha) begin
          rx_word[pos(nl)] <= dout;
          nl++;
        end else ns++;
        if (ne == 2 * len) begin
          ne = 0;
          nl = 0;
          ns = 0;
        end
      end
      idx = cpha ? ns - 1 : ns;
      // outside a character the line wanders when cpha is set, so a stale bit cannot pass; with cpha clear it holds the first bit
      din <= (idx >= 0 && idx < len) ? tx_word[pos(idx)] : ~din;
    end
  end
endmodule : syc_peer
`default_nettype wire

/* File: sim/test_syc_top.sv */
// self-checking bench for the synchronous serial channel
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; $display("[FAIL] %0t got %0h exp %0h", $time, a, e); end end
module test_syc_top;
  import syc_pkg::*;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, sclk_o, sclk_oe, dout_o, dout_oe, din_i, irq_tx, irq_rx, irq_err;
  logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic cpol = 0, cpha = 0, msb = 0, last = 0, sclk_s = 0;
  logic [4:0] len = 5'h08;
  logic [15:0] ptx = 16'h0000, prx;
  int errors = 0, comparisons = 0, n_tx = 0, n_rx = 0, n_err = 0, gap = 0, cnt = 0;
  syc_top u_syc_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .sclk_i(sclk_s), .sclk_o, .sclk_oe, .dout_o, .dout_oe, .din_i, .irq_tx, .irq_rx, .irq_err);
  // the shared clock line carries the block's clock while it drives, the bench's otherwise
  syc_peer u_syc_peer (.aclk, .aresetn, .sclk(sclk_oe ? sclk_o : sclk_s), .dout(dout_o), .din(din_i), .cpol, .cpha,
    .msb_first(msb), .len, .tx_word(ptx), .rx_word(prx));
  // clock, event counters and half-period meter
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    n_tx += irq_tx;
    n_rx += irq_rx;
    n_err += irq_err;
    if (sclk_o !== last) begin
      gap = cnt;
      cnt = 1;
    end else cnt++;
    last = sclk_o;
  end
  task automatic summarize();
    if (errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa, pw, pb;
    pa = 1; pw = 1; pb = 1;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    while (pb) begin
      @(posedge aclk);
      if (pa && s_axi_awready) begin pa = 0; s_axi_awvalid <= 0; end
      if (pw && s_axi_wready) begin pw = 0; s_axi_wvalid <= 0; end
      if (!pa && !pw && s_axi_bvalid) begin pb = 0; r = s_axi_bresp; s_axi_bready <= 0; end
    end
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    logic pa, pr;
    pa = 1; pr = 1;
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    while (pr) begin
      @(posedge aclk);
      if (pa && s_axi_arready) begin pa = 0; s_axi_arvalid <= 0; end
      if (!pa && s_axi_rvalid) begin pr = 0; d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0; end
    end
  endtask : rd
  // one master character; the peer answers with the inverse word
  task automatic xfer(input logic p, h, m, lb, rdb, input logic [4:0] l, input logic [15:0] w);
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] mk;
    int t0, r0;
    mk = 16'hFFFF >> (16 - l);
    cpol = p; cpha = h; msb = m; len = l; ptx = ~w;
    wr(ADDR_BAUD, 32'h00000002, r);
    wr(ADDR_CTRL, {20'h00000, 2'h3, lb, 1'b1, 1'b1, h, p, m, 4'(l - 1)}, r);
    @(posedge aclk); // pins follow the new control one cycle later
    `CHK(sclk_o, p)
    `CHK(sclk_oe, 1'b1)
    `CHK(dout_oe, 1'b1)
    t0 = n_tx; r0 = n_rx;
    wr(ADDR_TXD, {16'h0000, w}, r);
    `CHK(r, RESP_OKAY)
    for (int i = 0; i < 3000 && n_rx == r0; i++) @(posedge aclk);
    repeat (2) @(posedge aclk);
    `CHK(n_tx, t0 + 1)
    `CHK(n_rx, r0 + 1)
    `CHK(gap, 3)
    `CHK(prx & mk, w & mk)
    if (rdb) begin
      rd(ADDR_RXD, d, r);
      `CHK(d[15:0] & mk, (lb ? w : ptx) & mk)
    end
  endtask : xfer
  // register values after reset and refused addresses
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rd(ADDR_CTRL, d, r);
    `CHK(d, {16'h0000, CTRL_RESET})
    rd(ADDR_BAUD, d, r);
    `CHK(d, {16'h0000, BAUD_RESET})
    rd(5'h14, d, r);
    `CHK(r, RESP_SLVERR)
    wr(5'h14, 32'h0000FFFF, r);
    `CHK(r, RESP_SLVERR)
  endtask : t_reset
  // every polarity, phase and order with edge lengths
  task automatic t_modes();
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      xfer(c[0], c[1], c[2], 1'b0, 1'b1, (i == 0) ? 5'h02 : (i == 1) ? 5'h10 : 5'(3 + i),
           16'hA5C3 ^ 16'(i * 16'h1111));
    end
  endtask : t_modes
  // loop-back returns the sent word, then overrun of an unread buffer
  task automatic t_loop_overrun();
    logic [31:0] d;
    logic [1:0] r;
    int e0;
    xfer(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 5'h09, 16'h01B3);
    e0 = n_err;
    xfer(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 5'h08, 16'h005A);
    xfer(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 5'h08, 16'h00C6);
    rd(ADDR_STAT, d, r);
    `CHK(d[STAT_RX_ERR], 1'b1)
    `CHK(n_err > e0, 1'b1)
    wr(ADDR_STAT, 32'(1) << STAT_RX_ERR, r);
    rd(ADDR_RXD, d, r);
    `CHK(d[7:0], 8'h39)
    rd(ADDR_STAT, d, r);
    `CHK(d[STAT_RX_ERR], 1'b0)
    `CHK(d[STAT_RX_FULL], 1'b0)
  endtask : t_loop_overrun
  // slave frames clocked by the bench; the second finds no fresh data and resends
  task automatic t_slave();
    logic [31:0] d;
    logic [1:0] r;
    int t0, e0;
    cpol = 0; cpha = 0; msb = 0; len = 5'h08; ptx = 16'h00A7;
    wr(ADDR_CTRL, 32'h00000D07, r);
    wr(ADDR_TXD, 32'h0000005C, r);
    `CHK(sclk_oe, 1'b0)
    t0 = n_tx; e0 = n_err;
    for (int f = 0; f < 2; f++) begin
      repeat (16) begin
        repeat (3) @(posedge aclk);
        sclk_s <= ~sclk_s;
      end
      repeat (4) @(posedge aclk);
      `CHK(prx[7:0], 8'h5C)
      rd(ADDR_RXD, d, r);
      `CHK(d[7:0], 8'hA7)
    end
    rd(ADDR_STAT, d, r);
    `CHK(d[STAT_TX_ERR], 1'b1)
    `CHK(n_tx, t0 + 1)
    `CHK(n_err, e0 + 1)
  endtask : t_slave
  // main sequence and watchdog
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    t_reset();
    t_modes();
    t_loop_overrun();
    t_slave();
    summarize();
  end
  initial begin
    #1000000;
    errors++;
    summarize();
  end
endmodule : test_syc_top
`default_nettype wire
